// >>> common/papu_params.svh
// Purpose: Constants for the packed add and pack unit
// Assumes: Opcodes are the second byte after the 0f escape
// Notes:   Fault codes are this unit's own encoding
`ifndef PAPU_PARAMS_SVH
`define PAPU_PARAMS_SVH
`define PAPU_OP_PACK_UB   8'h67
`define PAPU_OP_ADD_B     8'hfc
`define PAPU_OP_ADD_W     8'hfd
`define PAPU_OP_ADD_D     8'hfe
`define PAPU_OP_ADDS_B    8'hec
`define PAPU_OP_ADDS_W    8'hed
`define PAPU_BYTE_MAX_U   8'hff
`define PAPU_BYTE_MIN_U   8'h00
`define PAPU_BYTE_MAX_S   8'h7f
`define PAPU_BYTE_MIN_S   8'h80
`define PAPU_WORD_MAX_S   16'h7fff
`define PAPU_WORD_MIN_S   16'h8000
`define PAPU_REAL_LIMIT   32'h0000ffff
`define PAPU_OPND_LAST    32'h00000007
`define PAPU_CPL_USER     2'h3
`define PAPU_ERR_ZERO     16'h0000
`define PAPU_VEC_REAL_GP  8'h0d
`endif

// >>> common/papu_pkg.sv
// Purpose: Types for the packed add and pack unit
// Assumes: Constants come from papu_params.svh
// Notes:   Fault kinds are ordered by priority, highest first, except PAPU_FAULT_REAL_INT13, which outranks page and alignment faults
package papu_pkg;
   typedef enum logic [1:0] {
      PAPU_MODE_PROT,
      PAPU_MODE_REAL,
      PAPU_MODE_V86
   } papu_mode_t;

   typedef enum logic [3:0] {
      PAPU_FAULT_NONE,
      PAPU_FAULT_INVALID_OPCODE,
      PAPU_FAULT_DEVICE_NOT_AVAIL,
      PAPU_FAULT_FLOAT_ERROR,
      PAPU_FAULT_GENERAL_PROT,
      PAPU_FAULT_STACK,
      PAPU_FAULT_PAGE,
      PAPU_FAULT_ALIGN_CHECK,
      PAPU_FAULT_REAL_INT13
   } papu_fault_t;

   typedef struct packed {
      logic        valid;
      logic [7:0]  opcode;
      logic [63:0] dst;
      logic [63:0] reg_src;
      logic        src_is_mem;
      logic [31:0] mem_addr;
      logic        seg_is_stack;
      logic        seg_illegal;
      logic        page_miss;
      logic [63:0] mem_data;
   } papu_req_t;

   typedef struct packed {
      logic        emulation_bit;
      logic        task_switched_bit;
      logic        float_pending;
      papu_mode_t  mode;
      logic [1:0]  cpl;
      logic        align_enable;
   } papu_ctrl_t;

   typedef struct packed {
      logic        valid;
      logic        write_dst;
      logic [63:0] result;
      papu_fault_t fault;
      logic        has_err_code;
      logic [15:0] err_code;
      logic [7:0]  vector;
   } papu_resp_t;

   typedef struct packed {
      papu_resp_t resp;
   } papu_state_t;
endpackage

// >>> design/papu_unit.sv
// Purpose: Packed pack and add execution unit, one result per request
// Assumes: Decoder holds ctrl stable with the request; inputs synchronous
// Notes:   Result one cycle after a valid request; flags never touched
`timescale 1ns/1ps
`include "papu_params.svh"
module papu_unit #(
   parameter int LANES_B = 8
) (
   input  wire logic                 core_clk,
   input  wire logic                 rst_b,
   input  wire papu_pkg::papu_req_t  req,
   input  wire papu_pkg::papu_ctrl_t ctrl,
   output papu_pkg::papu_resp_t      resp
);
   if (LANES_B != 8)
   begin : g_lanes_check
      $error("papu_unit serves only a 64-bit register of eight byte lanes");
   end

   papu_pkg::papu_state_t st;
   papu_pkg::papu_state_t next_st;

   logic [63:0] src;
   logic [63:0] pack_r;
   logic [63:0] add_b;
   logic [63:0] add_w;
   logic [63:0] add_d;
   logic [63:0] sat_b;
   logic [63:0] sat_w;
   logic [63:0] last_byte;
   logic        unaligned;
   logic        known_op;
   logic        issue_ok;

   // Source is a register or a 64-bit load; destination always a register
   assign src = req.src_is_mem ? req.mem_data : req.reg_src;

   // Lane carries are cut per lane so no lane sees its neighbour
   genvar g;
   generate
      for (g = 0; g < LANES_B; g++)
      begin : g_byte
         logic [8:0] s9;
         logic [7:0] a;
         logic [7:0] b;
         logic [7:0] s;
         assign a  = req.dst[8*g +: 8];
         assign b  = src[8*g +: 8];
         assign s9 = {1'b0, a} + {1'b0, b};
         assign s  = s9[7:0];
         assign add_b[8*g +: 8] = s;
         // Signed overflow only when equal signs give a different sign
         assign sat_b[8*g +: 8] = (a[7] == b[7] && s[7] != a[7])
                                  ? (a[7] ? `PAPU_BYTE_MIN_S : `PAPU_BYTE_MAX_S) : s;
      end
      for (g = 0; g < LANES_B / 2; g++)
      begin : g_word
         logic [15:0] a;
         logic [15:0] b;
         logic [15:0] s;
         logic [16:0] s17;
         assign a   = req.dst[16*g +: 16];
         assign b   = src[16*g +: 16];
         assign s17 = {1'b0, a} + {1'b0, b};
         assign s   = s17[15:0];
         assign add_w[16*g +: 16] = s;
         assign sat_w[16*g +: 16] = (a[15] == b[15] && s[15] != a[15])
                                    ? (a[15] ? `PAPU_WORD_MIN_S : `PAPU_WORD_MAX_S) : s;
         // Destination words low half, source words high half
         assign pack_r[8*g +: 8] = clamp_u8(req.dst[16*g +: 16]);
         assign pack_r[32 + 8*g +: 8] = clamp_u8(src[16*g +: 16]);
      end
      for (g = 0; g < LANES_B / 4; g++)
      begin : g_dword
         logic [32:0] s33;
         assign s33 = {1'b0, req.dst[32*g +: 32]} + {1'b0, src[32*g +: 32]};
         assign add_d[32*g +: 32] = s33[31:0];
      end
   endgenerate

   function automatic logic [7:0] clamp_u8(input logic [15:0] v);
      logic [7:0] r;
      r = v[7:0];
      if (v[15])
         r = `PAPU_BYTE_MIN_U;
      else if (v[14:8] != 7'h00)
         r = `PAPU_BYTE_MAX_U;
      return r;
   endfunction

   assign last_byte = {32'h00000000, req.mem_addr} + {32'h00000000, `PAPU_OPND_LAST};
   assign unaligned = req.mem_addr[2:0] != 3'h0;
   assign known_op  = req.opcode == `PAPU_OP_PACK_UB || req.opcode == `PAPU_OP_ADD_B
                   || req.opcode == `PAPU_OP_ADD_W || req.opcode == `PAPU_OP_ADD_D
                   || req.opcode == `PAPU_OP_ADDS_B || req.opcode == `PAPU_OP_ADDS_W;
   // Past the fault gates that do not depend on the operand location
   assign issue_ok  = req.valid && known_op && !ctrl.emulation_bit
                   && !ctrl.task_switched_bit && !ctrl.float_pending;

   always_comb
   begin
      next_st = '0;
      next_st.resp.valid = req.valid;
      next_st.resp.fault = papu_pkg::PAPU_FAULT_NONE;
      if (req.valid)
      begin
         if (ctrl.emulation_bit || !known_op)
            next_st.resp.fault = papu_pkg::PAPU_FAULT_INVALID_OPCODE;
         else if (ctrl.task_switched_bit)
            next_st.resp.fault = papu_pkg::PAPU_FAULT_DEVICE_NOT_AVAIL;
         else if (ctrl.float_pending)
            next_st.resp.fault = papu_pkg::PAPU_FAULT_FLOAT_ERROR;
         else if (req.src_is_mem && ctrl.mode == papu_pkg::PAPU_MODE_PROT)
         begin
            if (req.seg_illegal)
            begin
               next_st.resp.fault = req.seg_is_stack ? papu_pkg::PAPU_FAULT_STACK
                                                     : papu_pkg::PAPU_FAULT_GENERAL_PROT;
               next_st.resp.has_err_code = 1'b1;
               next_st.resp.err_code = `PAPU_ERR_ZERO;
            end
            else if (req.page_miss)
               next_st.resp.fault = papu_pkg::PAPU_FAULT_PAGE;
            else if (unaligned && ctrl.align_enable && ctrl.cpl == `PAPU_CPL_USER)
               next_st.resp.fault = papu_pkg::PAPU_FAULT_ALIGN_CHECK;
         end
         else if (req.src_is_mem)
         begin
            if (last_byte > {32'h00000000, `PAPU_REAL_LIMIT})
            begin
               next_st.resp.fault = papu_pkg::PAPU_FAULT_REAL_INT13;
               next_st.resp.vector = `PAPU_VEC_REAL_GP;
            end
            else if (ctrl.mode == papu_pkg::PAPU_MODE_V86 && req.page_miss)
               next_st.resp.fault = papu_pkg::PAPU_FAULT_PAGE;
            else if (ctrl.mode == papu_pkg::PAPU_MODE_V86 && unaligned && ctrl.align_enable)
               next_st.resp.fault = papu_pkg::PAPU_FAULT_ALIGN_CHECK;
         end
         if (next_st.resp.fault == papu_pkg::PAPU_FAULT_NONE)
         begin
            next_st.resp.write_dst = 1'b1;
            unique case (req.opcode)
               `PAPU_OP_PACK_UB: next_st.resp.result = pack_r;
               `PAPU_OP_ADD_B:   next_st.resp.result = add_b;
               `PAPU_OP_ADD_W:   next_st.resp.result = add_w;
               `PAPU_OP_ADD_D:   next_st.resp.result = add_d;
               `PAPU_OP_ADDS_B:  next_st.resp.result = sat_b;
               default:          next_st.resp.result = sat_w;
            endcase
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
         st <= '0;
      else
         st <= next_st;
   end

   assign resp = st.resp;

   pack_clamp_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      req.valid && req.opcode == `PAPU_OP_PACK_UB && !req.dst[15] && req.dst[15:8] != 8'h00
      && !ctrl.emulation_bit && !ctrl.task_switched_bit && !ctrl.float_pending && !req.src_is_mem
      |=> resp.result[7:0] == 8'hff)
      else $error("pack overflow not clamped to ff");

   pack_order_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      resp.write_dst && $past(req.opcode) == `PAPU_OP_PACK_UB && !$past(src[63])
      && $past(src[63:56]) == 8'h00 |-> resp.result[63:56] == $past(src[55:48]))
      else $error("pack source word landed in wrong byte");

   add_byte_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      resp.write_dst && $past(req.opcode) == `PAPU_OP_ADD_B
      |-> resp.result[15:8] == 8'($past(req.dst[15:8]) + $past(src[15:8])))
      else $error("byte add carried across lanes");

   add_word_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      resp.write_dst && $past(req.opcode) == `PAPU_OP_ADD_W
      |-> resp.result[31:16] == 16'($past(req.dst[31:16]) + $past(src[31:16])))
      else $error("word add wrong");

   add_dword_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      resp.write_dst && $past(req.opcode) == `PAPU_OP_ADD_D
      |-> resp.result[63:32] == 32'($past(req.dst[63:32]) + $past(src[63:32])))
      else $error("dword add wrong");

   sat_byte_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      resp.write_dst && $past(req.opcode) == `PAPU_OP_ADDS_B
      && !$past(req.dst[7]) && !$past(src[7]) && $past(add_b[7]) |-> resp.result[7:0] == 8'h7f)
      else $error("signed byte overflow not clamped");

   sat_word_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      resp.write_dst && $past(req.opcode) == `PAPU_OP_ADDS_W
      && $past(req.dst[15]) && $past(src[15]) && !$past(add_w[15]) |-> resp.result[15:0] == 16'h8000)
      else $error("signed word underflow not clamped");

   emul_fault_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      req.valid && ctrl.emulation_bit |=> resp.fault == papu_pkg::PAPU_FAULT_INVALID_OPCODE && !resp.write_dst)
      else $error("emulation bit did not fault");

   float_fault_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      req.valid && !ctrl.emulation_bit && !ctrl.task_switched_bit && ctrl.float_pending && known_op
      |=> resp.fault == papu_pkg::PAPU_FAULT_FLOAT_ERROR)
      else $error("pending float error ignored");

   real_limit_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      req.valid && req.src_is_mem && ctrl.mode == papu_pkg::PAPU_MODE_REAL && req.mem_addr == 32'h0000fff9
      && !ctrl.emulation_bit && !ctrl.task_switched_bit && !ctrl.float_pending && known_op
      |=> resp.fault == papu_pkg::PAPU_FAULT_REAL_INT13 && resp.vector == 8'h0d)
      else $error("real-mode limit not enforced");

   dev_fault_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      req.valid && known_op && !ctrl.emulation_bit && ctrl.task_switched_bit
      |=> resp.fault == papu_pkg::PAPU_FAULT_DEVICE_NOT_AVAIL && !resp.write_dst)
      else $error("task-switched bit did not fault");

   fault_quiet_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      resp.valid && resp.fault != papu_pkg::PAPU_FAULT_NONE
      |-> !resp.write_dst && resp.result == 64'h0000000000000000)
      else $error("faulting request still wrote a result");

   src_select_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      resp.write_dst && $past(req.opcode) == `PAPU_OP_ADD_D
      |-> resp.result[31:0] == 32'($past(req.dst[31:0])
          + ($past(req.src_is_mem) ? $past(req.mem_data[31:0]) : $past(req.reg_src[31:0]))))
      else $error("source operand taken from the wrong place");

   seg_fault_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      issue_ok && req.src_is_mem && ctrl.mode == papu_pkg::PAPU_MODE_PROT && req.seg_illegal
      |=> resp.has_err_code && resp.err_code == `PAPU_ERR_ZERO
          && resp.fault == ($past(req.seg_is_stack) ? papu_pkg::PAPU_FAULT_STACK
                                                    : papu_pkg::PAPU_FAULT_GENERAL_PROT))
      else $error("segment fault kind or error code wrong");

   prot_page_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      issue_ok && req.src_is_mem && ctrl.mode == papu_pkg::PAPU_MODE_PROT
      && !req.seg_illegal && req.page_miss
      |=> resp.fault == papu_pkg::PAPU_FAULT_PAGE)
      else $error("paging miss did not page-fault");

   user_align_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      issue_ok && req.src_is_mem && ctrl.mode == papu_pkg::PAPU_MODE_PROT
      && !req.seg_illegal && !req.page_miss && req.mem_addr[2:0] != 3'h0 && ctrl.align_enable
      |=> resp.fault == ($past(ctrl.cpl) == `PAPU_CPL_USER ? papu_pkg::PAPU_FAULT_ALIGN_CHECK
                                                            : papu_pkg::PAPU_FAULT_NONE))
      else $error("alignment fault not tied to privilege 3");

   v86_page_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      issue_ok && req.src_is_mem && ctrl.mode == papu_pkg::PAPU_MODE_V86
      && req.mem_addr <= `PAPU_REAL_LIMIT - `PAPU_OPND_LAST && req.page_miss
      |=> resp.fault == papu_pkg::PAPU_FAULT_PAGE)
      else $error("virtual-8086 paging miss did not page-fault");

   v86_align_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      issue_ok && req.src_is_mem && ctrl.mode == papu_pkg::PAPU_MODE_V86
      && req.mem_addr <= `PAPU_REAL_LIMIT - `PAPU_OPND_LAST && !req.page_miss
      && req.mem_addr[2:0] != 3'h0 && ctrl.align_enable
      |=> resp.fault == papu_pkg::PAPU_FAULT_ALIGN_CHECK)
      else $error("virtual-8086 unaligned operand did not fault");

   real_inrange_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      issue_ok && req.src_is_mem && ctrl.mode == papu_pkg::PAPU_MODE_REAL
      && req.mem_addr <= `PAPU_REAL_LIMIT - `PAPU_OPND_LAST
      |=> resp.fault == papu_pkg::PAPU_FAULT_NONE && resp.write_dst)
      else $error("real-mode operand inside limit faulted");

   pack_neg_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      issue_ok && !req.src_is_mem && req.opcode == `PAPU_OP_PACK_UB
      && req.dst[63]
      |=> resp.result[31:24] == `PAPU_BYTE_MIN_U)
      else $error("negative destination word not clamped to zero");

   pack_src_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      issue_ok && !req.src_is_mem && req.opcode == `PAPU_OP_PACK_UB
      && !req.reg_src[15] && req.reg_src[15:8] != 8'h00
      |=> resp.result[39:32] == `PAPU_BYTE_MAX_U)
      else $error("source word zero not packed into byte four");

   lane_alone_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      resp.write_dst && $past(req.opcode) == `PAPU_OP_ADDS_W && $past(req.dst[63]) != $past(src[63])
      |-> resp.result[63:48] == 16'($past(req.dst[63:48]) + $past(src[63:48])))
      else $error("word lane result leaked from another lane");

   sat_byte_low_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      resp.write_dst && $past(req.opcode) == `PAPU_OP_ADDS_B
      && $past(req.dst[63]) && $past(src[63]) && !$past(add_b[63])
      |-> resp.result[63:56] == `PAPU_BYTE_MIN_S)
      else $error("signed byte underflow not clamped");
endmodule

// >>> dv/papu_feeder.sv
// Purpose: Decoder, register file and load unit in front of the unit
// Assumes: One issue call per request, driven just after an edge
// Notes:   Idle and unselected payload is inverted so stale data never matches
`timescale 1ns/1ps
module papu_feeder (
   input  wire logic            core_clk,
   output papu_pkg::papu_req_t  req,
   output papu_pkg::papu_ctrl_t ctrl
);
   initial
   begin
      req = '0;
      ctrl = '0;
   end
   task automatic idle(input int n);
      papu_pkg::papu_req_t q;
      repeat (n)
      begin
         @(posedge core_clk);
         #1;
         q = ~req;
         q.valid = 1'b0;
         req = q;
      end
   endtask
   // Held one edge only: the decoder may issue every cycle
   task automatic issue(input papu_pkg::papu_req_t r, input papu_pkg::papu_ctrl_t c);
      papu_pkg::papu_req_t q;
      q = r;
      if (q.src_is_mem)
         q.reg_src = ~req.reg_src;
      else
         q.mem_data = ~req.mem_data;
      @(posedge core_clk);
      #1;
      req = q;
      ctrl = c;
   endtask
endmodule

// >>> dv/tb_packed_add_pack_unit.sv
// Purpose: Self-checking bench for the packed pack and add unit
// Assumes: Each answer lands one edge after its request
// Notes:   Expected results are rebuilt lane by lane from the operands
`timescale 1ns/1ps
`include "papu_params.svh"
module tb_packed_add_pack_unit;
   logic                 core_clk = 1'b0;
   logic                 rst_b = 1'b0;
   papu_pkg::papu_req_t  req;
   papu_pkg::papu_req_t  prev_req;
   papu_pkg::papu_req_t  r;
   papu_pkg::papu_ctrl_t ctrl;
   papu_pkg::papu_ctrl_t prev_ctrl;
   papu_pkg::papu_ctrl_t c;
   papu_pkg::papu_resp_t resp;
   logic                 prev_live = 1'b0;
   logic [255:0]         rr;
   logic [7:0]           ops [7] = '{`PAPU_OP_PACK_UB, `PAPU_OP_ADD_B, `PAPU_OP_ADD_W, `PAPU_OP_ADD_D,
                                     `PAPU_OP_ADDS_B, `PAPU_OP_ADDS_W, 8'h00};
   // Ctrl bits em,ts,fp,mode,cpl,align then address
   logic [39:0]          fc [8] = '{{8'he0, 32'h0}, {8'h60, 32'h0}, {8'h20, 32'h0}, {8'h08, 32'hfff8},
                                    {8'h08, 32'hfff9}, {8'h07, 32'h1}, {8'h05, 32'h1}, {8'h11, 32'h2}};
   int                   miscompares = 0;
   int                   n_tests = 0;
   int                   seed = 32'hac43;
   always #10 core_clk = ~core_clk;
   papu_feeder u_papu_feeder (.core_clk(core_clk), .req(req), .ctrl(ctrl));
   papu_unit #(.LANES_B(8)) u_papu_unit (.core_clk(core_clk), .rst_b(rst_b), .req(req), .ctrl(ctrl), .resp(resp));
   function automatic logic [7:0] sat_ub(input logic [15:0] w);
      if (w[15])
         return `PAPU_BYTE_MIN_U;
      return (w > 16'h00ff) ? `PAPU_BYTE_MAX_U : w[7:0];
   endfunction
   function automatic papu_pkg::papu_resp_t calc(input papu_pkg::papu_req_t q, input papu_pkg::papu_ctrl_t k);
      papu_pkg::papu_resp_t o;
      logic [63:0]          s;
      logic [16:0]          t;
      logic                 bad;
      logic                 al;
      o = '0;
      o.valid = 1'b1;
      s = q.src_is_mem ? q.mem_data : q.reg_src;
      al = k.align_enable && q.mem_addr[2:0] != 3'h0;
      bad = 1'b1;
      for (int j = 0; j < 6; j++)
         if (q.opcode == ops[j])
            bad = 1'b0;
      for (int i = 0; i < 8; i++)
      begin
         t = {q.dst[8*i+7], q.dst[8*i+:8]} + {s[8*i+7], s[8*i+:8]};
         if (q.opcode == `PAPU_OP_PACK_UB)
            o.result[8*i+:8] = sat_ub(i < 4 ? q.dst[16*i+:16] : s[16*i-64+:16]);
         if (q.opcode == `PAPU_OP_ADD_B)
            o.result[8*i+:8] = t[7:0];
         if (q.opcode == `PAPU_OP_ADDS_B)
            o.result[8*i+:8] = (t[8] != t[7]) ? (t[8] ? `PAPU_BYTE_MIN_S : `PAPU_BYTE_MAX_S) : t[7:0];
      end
      for (int i = 0; i < 4; i++)
      begin
         t = {q.dst[16*i+15], q.dst[16*i+:16]} + {s[16*i+15], s[16*i+:16]};
         if (q.opcode == `PAPU_OP_ADD_W)
            o.result[16*i+:16] = t[15:0];
         if (q.opcode == `PAPU_OP_ADDS_W)
            o.result[16*i+:16] = (t[16] != t[15]) ? (t[16] ? `PAPU_WORD_MIN_S : `PAPU_WORD_MAX_S) : t[15:0];
      end
      if (q.opcode == `PAPU_OP_ADD_D)
         o.result = {q.dst[63:32] + s[63:32], q.dst[31:0] + s[31:0]};
      if (k.emulation_bit || bad)
         o.fault = papu_pkg::PAPU_FAULT_INVALID_OPCODE;
      else if (k.task_switched_bit)
         o.fault = papu_pkg::PAPU_FAULT_DEVICE_NOT_AVAIL;
      else if (k.float_pending)
         o.fault = papu_pkg::PAPU_FAULT_FLOAT_ERROR;
      else if (q.src_is_mem && k.mode == papu_pkg::PAPU_MODE_PROT)
      begin
         if (q.seg_illegal)
            o.fault = q.seg_is_stack ? papu_pkg::PAPU_FAULT_STACK : papu_pkg::PAPU_FAULT_GENERAL_PROT;
         else if (q.page_miss)
            o.fault = papu_pkg::PAPU_FAULT_PAGE;
         else if (k.cpl == `PAPU_CPL_USER && al)
            o.fault = papu_pkg::PAPU_FAULT_ALIGN_CHECK;
      end
      else if (q.src_is_mem && q.mem_addr > `PAPU_REAL_LIMIT - `PAPU_OPND_LAST)
         o.fault = papu_pkg::PAPU_FAULT_REAL_INT13;
      else if (q.src_is_mem && k.mode == papu_pkg::PAPU_MODE_V86)
      begin
         if (q.page_miss)
            o.fault = papu_pkg::PAPU_FAULT_PAGE;
         else if (al)
            o.fault = papu_pkg::PAPU_FAULT_ALIGN_CHECK;
      end
      o.has_err_code = o.fault inside {papu_pkg::PAPU_FAULT_STACK, papu_pkg::PAPU_FAULT_GENERAL_PROT};
      o.vector = (o.fault == papu_pkg::PAPU_FAULT_REAL_INT13) ? `PAPU_VEC_REAL_GP : 8'h00;
      o.write_dst = (o.fault == papu_pkg::PAPU_FAULT_NONE);
      if (!o.write_dst)
         o.result = '0;
      return o;
   endfunction
   task automatic check(input string name, input papu_pkg::papu_resp_t seen, input papu_pkg::papu_resp_t exp);
      n_tests++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic report_and_stop;
      $display("checks %0d miscompares %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic go(input logic [7:0] op, input logic m, input logic [31:0] a, input papu_pkg::papu_ctrl_t k);
      r = '0;
      r.valid = 1'b1;
      r.opcode = op;
      r.dst = 64'h7fff_ff80_ffff_00ff;
      r.reg_src = 64'h0101_ff80_0001_0101;
      r.mem_data = r.reg_src;
      r.src_is_mem = m;
      r.mem_addr = a;
      u_papu_feeder.issue(r, k);
   endtask
   // Request kept from the edge that takes it; its answer is checked mid-cycle, once settled
   always @(posedge core_clk)
   begin
      prev_req <= req;
      prev_ctrl <= ctrl;
      prev_live <= rst_b;
   end
   always @(negedge core_clk)
   begin
      if (rst_b && prev_live && prev_req.valid)
         check("resp", resp, calc(prev_req, prev_ctrl));
      else
         check("resp", resp, papu_pkg::papu_resp_t'(0));
   end
   initial
   begin
      repeat (20000) @(posedge core_clk);
      miscompares++;
      report_and_stop;
   end
   initial
   begin
      repeat (12) @(posedge core_clk);
      #1;
      rst_b = 1'b1;
      for (int m = 0; m < 2; m++)
         for (int i = 0; i < 7; i++)
            go(ops[i], m[0], 32'h0, '0);
      for (int i = 0; i < 8; i++)
         go(`PAPU_OP_ADD_B, 1'b1, fc[i][31:0], fc[i][39:32]);
      for (int k = 0; k < 600; k++)
      begin
         for (int j = 0; j < 8; j++)
            rr[32*j+:32] = $random(seed);
         r = rr[236:0];
         c = rr[244:237];
         r.valid = 1'b1;
         r.opcode = ops[k % 7];
         r.seg_illegal &= (k % 3 == 0);
         r.page_miss &= (k % 5 == 0);
         if (k % 2)
            r.mem_addr[31:16] = 16'h0;
         if (k % 4)
            c[7:5] = 3'h0;
         if (c.mode === 2'h3)
            c.mode = papu_pkg::PAPU_MODE_REAL;
         u_papu_feeder.idle(rr[255:254]);
         u_papu_feeder.issue(r, c);
      end
      u_papu_feeder.idle(2);
      rst_b = 1'b0;
      u_papu_feeder.idle(3);
      rst_b = 1'b1;
      go(`PAPU_OP_ADD_W, 1'b0, 32'h0, '0);
      u_papu_feeder.idle(3);
      report_and_stop;
   end
endmodule
